/* File: src/pcc_timing_regs.svh */
// Purpose: register indexes, field positions, reset values, timing counts
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef PCC_TIMING_REGS_SVH
`define PCC_TIMING_REGS_SVH

// timing register indexes, set 0 then set 1
`define IDX_SETUP0  8'h3A
`define IDX_CMD0    8'h3B
`define IDX_REC0    8'h3C
`define IDX_SETUP1  8'h3D
`define IDX_CMD1    8'h3E
`define IDX_REC1    8'h3F
// control, prescaler, launch, data and status words
`define IDX_CTRL    8'h40
`define IDX_PRESC   8'h41
`define IDX_CYCLE   8'h42
`define IDX_WDATA   8'h43
`define IDX_STATUS  8'h44

// reset values
`define RST_SETUP   8'h01
`define RST_CMD     8'h06
`define RST_REC     8'h03
`define RST_PRESC   8'h01

// control word bit positions
`define CTRL_SET    0
`define CTRL_DMA_EN 1
`define CTRL_DMA_WR 2
`define CTRL_HOST16 3
`define CTRL_W      4
// prescaler word: set 0 in the low byte, set 1 in the next
`define PRESC1_LO   8
// launch word: kind 30:28, odd 27, attribute 26, address 25:0
`define CYC_W       31

// internal clock period and bus clock period, ns
`define TCP_NS      40
`define CLK_NS      8
`define TCP_CYC     (`TCP_NS / `CLK_NS)
// command tail after wait release, and iois16 window, in periods
`define WAIT_TAIL   2
`define IOIS_WIN    3

`endif

/* File: src/pcc_timing_pkg.sv */
// Purpose: types shared by the socket cycle sequencer
// Assumes: one socket, one bus clock
// Notes: field order of cycle_s matches the launch word
package pcc_timing_pkg;

    typedef enum logic [2:0] {
        K_MEM_RD, K_MEM_WR, K_IO_RD, K_IO_WR, K_DMA_RD, K_DMA_WR
    } kind_e;

    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_CMD, S_TAIL, S_RECOV
    } state_e;

    typedef struct packed {
        kind_e       kind;
        logic        odd;
        logic        attr;
        logic [25:0] addr;
    } cycle_s;

    // socket strobes, all active low
    typedef struct packed {
        logic [1:0] ce_n;
        logic       reg_n;
        logic       oe_n;
        logic       we_n;
        logic       iord_n;
        logic       iowr_n;
    } sock_s;

endpackage : pcc_timing_pkg

/* File: src/stream_fifo.sv */
// Purpose: small valid/ready FIFO for socket write data
// Assumes: DEPTH is a power of two
// Notes: storage is flip-flops without reset
`timescale 1ns/10ps
module stream_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,       // clock
    input  wire logic             rst_n,     // async reset, low
    input  wire logic             in_valid,  // producer offers a word
    output logic                  in_ready,  // room for a word
    input  wire logic [WIDTH-1:0] in_data,   // word in
    output logic                  out_valid, // a word is held
    input  wire logic             out_ready, // consumer takes it
    output logic      [WIDTH-1:0] out_data   // oldest word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      fill;

    // handshakes and flags
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data  = mem[rp];

    // storage
    always_ff @(posedge clk) begin
        if (push) mem[wp] <= in_data;
    end

    // pointers wrap naturally at a power-of-two depth
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp   <= '0;
            rp   <= '0;
            fill <= '0;
        end else begin
            wp   <= push ? wp + AW'(1) : wp;
            rp   <= pop ? rp + AW'(1) : rp;
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : stream_fifo

/* File: src/pc_card_cycle_timing_dma.sv */
// Purpose: socket strobe sequencer with programmable timing and DMA
// Assumes: AHB-Lite single word transfers, one socket
// Notes: socket timing counts run on a 25 MHz enable from hclk
// Overview of operation
// - setup lasts prescaler_count times value_count plus one periods, set 0 default 01h.
// - command strobe lasts the same product from the command count, set 0 default 06h.
// - recovery after the strobe lasts the recovery product, set 0 default 03h.
// - address and qualifiers lead, then the strobe, then address is held through recovery.
// - all counts are in internal periods of 40 ns, a 25 MHz rate.
// - a DMA read strobes -IOWR and passes terminal count on -WE while it is active.
// - a DMA write strobes -IORD and passes terminal count on -OE while it is active.
// - the strobe stays active at least two periods after wait is released.
// - DMA requests are withheld until the write-data FIFO is empty.
// - on an odd byte to an 8-bit I/O card, CE2 rises and CE1 drops when the IOIS16 window ends with IOIS16 never seen.
// - IOIS16 arriving after that window is ignored and the access is byte wide.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "pcc_timing_regs.svh"
module pc_card_cycle_timing_dma
    import pcc_timing_pkg::*;
#(
    parameter int DATA_W     = 16,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic              hclk,       // bus clock
    input  wire logic              hresetn,    // async reset, low
    input  wire logic              hsel,       // slave select
    input  wire logic [31:0]       haddr,      // byte address
    input  wire logic [1:0]        htrans,     // transfer type
    input  wire logic              hwrite,     // write phase
    input  wire logic [2:0]        hsize,      // word only
    input  wire logic [31:0]       hwdata,     // write data
    input  wire logic              hready,     // bus ready
    output logic      [31:0]       hrdata,     // read data
    output logic                   hreadyout,  // slave ready
    output logic                   hresp,      // always okay
    output sock_s                  sock,       // socket strobes
    output logic      [25:0]       card_addr,  // socket address
    output logic      [DATA_W-1:0] card_dout,  // socket data out
    output logic                   card_doe,   // data out enable
    input  wire logic [DATA_W-1:0] card_din,   // socket data in
    input  wire logic              wait_n,     // card wait
    input  wire logic              iois16_n,   // card 16-bit io
    output logic                   dma_req,    // request to host
    input  wire logic              dma_ack,    // host acknowledge
    input  wire logic              dma_tc,     // host terminal count
    input  wire logic [DATA_W-1:0] dma_wdata,  // host data for dma read
    output logic      [DATA_W-1:0] dma_rdata   // last data from card
);
    localparam int        TCPC     = `TCP_CYC;
    localparam logic [2:0] DIV_LAST = 3'(`TCP_CYC - 1);
    localparam logic [1:0] WIN      = 2'(`IOIS_WIN);
    localparam int        SW       = DATA_W + 4;
    localparam logic [SW-1:0] PIN_RST = {{DATA_W{1'b0}}, 4'hC};
    localparam sock_s     SOCK_IDLE = '1;

    // count of internal periods for one timing register
    function automatic logic [15:0] calc_len(input logic [7:0] p, input logic [7:0] v);
        calc_len = 16'(16'(p) * 16'(v) + 16'h0001);
    endfunction : calc_len

    // kinds that drive data toward the card
    function automatic logic drives_data(input kind_e k);
        drives_data = (k == K_MEM_WR) || (k == K_IO_WR) || (k == K_DMA_RD);
    endfunction : drives_data

    // internal period enable, five bus clocks apart
    logic [2:0] div;
    logic       tick;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div  <= 3'h0;
            tick <= 1'b0;
        end else begin
            div  <= (div == DIV_LAST) ? 3'h0 : div + 3'h1;
            tick <= (div == DIV_LAST);
        end
    end

    // pins from the card, and dma_ack and dma_tc from the host, pass two flops before use
    logic [SW-1:0] pin_s1;
    logic [SW-1:0] pin_s2;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= PIN_RST;
            pin_s2 <= PIN_RST;
        end else begin
            pin_s1 <= {card_din, wait_n, iois16_n, dma_ack, dma_tc};
            pin_s2 <= pin_s1;
        end
    end
    wire [DATA_W-1:0] din_s  = pin_s2[SW-1:4];
    wire              wait_s = pin_s2[3];
    wire              iois_s = pin_s2[2];
    wire              dack_s = pin_s2[1];
    wire              tc_s   = pin_s2[0];

    // software registers
    logic [7:0]        timing [0:5];
    logic [7:0]        presc [0:1];
    logic [`CTRL_W-1:0] ctrl;
    logic              pend;
    cycle_s            pend_cmd;
    logic [DATA_W-1:0] rd_latch;

    // bus address phase decode
    wire        ap     = hsel && hready && htrans[1];
    wire [7:0]  ap_idx = haddr[9:2];
    wire        ap_low = (haddr[31:10] == 22'h0);
    wire        ap_tim = ap_low && ap_idx >= `IDX_SETUP0 && ap_idx <= `IDX_REC1;
    wire [2:0]  ap_off = 3'(ap_idx - `IDX_SETUP0);
    logic       dp_wr;
    logic [7:0] dp_idx;
    wire        dp_tim = dp_idx >= `IDX_SETUP0 && dp_idx <= `IDX_REC1;
    wire [2:0]  dp_off = 3'(dp_idx - `IDX_SETUP0);
    wire        wr_en  = dp_wr && hreadyout;

    // fifo hookup: a data word stalls the bus while the fifo is full
    wire               f_in_valid = dp_wr && !hreadyout && dp_idx == `IDX_WDATA;
    logic              f_in_ready;
    logic              f_out_valid;
    logic              f_out_ready;
    logic [DATA_W-1:0] f_out_data;
    wire               f_empty = !f_out_valid;

    stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) wfifo (
        .clk       (hclk),
        .rst_n     (hresetn),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (hwdata[DATA_W-1:0]),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // sequencer state
    state_e      state;
    state_e      next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [15:0] lat_s;
    logic [15:0] lat_c;
    logic [15:0] lat_r;
    logic        waited;
    logic        tc_seen;
    logic [1:0]  win;
    logic        io16;
    cycle_s      cur;

    // status word read back
    wire busy = (state != S_IDLE) || pend;
    wire [31:0] status = {rd_latch, 11'h0, io16, dma_req, !f_in_ready, f_empty, busy};

    // read mux, unmapped words read zero
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0;
        if (ap_tim) rd_word = {24'h0, timing[ap_off]};
        else if (ap_low) begin
            unique case (ap_idx)
                `IDX_CTRL:   rd_word = {28'h0, ctrl};
                `IDX_PRESC:  rd_word = {16'h0, presc[1], presc[0]};
                `IDX_CYCLE:  rd_word = {1'b0, pend_cmd};
                `IDX_STATUS: rd_word = status;
                default:     rd_word = 32'h0;
            endcase
        end
    end

    // bus phases: reads answer with no wait, fifo words wait for room
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr     <= 1'b0;
            dp_idx    <= 8'h0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            if (hready) begin
                dp_wr  <= ap && hwrite && ap_low;
                dp_idx <= ap_idx;
                hrdata <= (ap && !hwrite) ? rd_word : 32'h0;
            end
            if (ap && hwrite && ap_low && ap_idx == `IDX_WDATA) hreadyout <= 1'b0;
            else if (f_in_valid && f_in_ready) hreadyout <= 1'b1;
        end
    end

    // timer set selection and lengths for the next cycle
    wire         set1  = ctrl[`CTRL_SET];
    wire [2:0]   tb    = set1 ? 3'd3 : 3'd0;
    wire [7:0]   p_sel = presc[set1];
    wire [15:0]  s_len = calc_len(p_sel, timing[tb]);
    wire [15:0]  c_len = calc_len(p_sel, timing[3'(tb + 3'd1)]);
    wire [15:0]  r_len = calc_len(p_sel, timing[3'(tb + 3'd2)]);

    // cycle start: a launched cycle first, then an acknowledged dma
    wire    go_prog = pend && (!drives_data(pend_cmd.kind) || f_out_valid);
    wire    go_dma  = ctrl[`CTRL_DMA_EN] && dack_s && !pend;
    wire    start   = tick && state == S_IDLE && (go_prog || go_dma);
    wire    last    = tick && cnt == 16'h1;
    wire    launch  = wr_en && dp_idx == `IDX_CYCLE && !pend;
    wire kind_e dma_kind = ctrl[`CTRL_DMA_WR] ? K_DMA_WR : K_DMA_RD;
    wire cycle_s start_cmd = go_prog ? pend_cmd : cycle_s'({dma_kind, 28'h0});
    assign f_out_ready = start && go_prog && drives_data(pend_cmd.kind);

    // register writes and launch bookkeeping
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 6; i++)
                timing[i] <= (i % 3 == 0) ? `RST_SETUP : (i % 3 == 1) ? `RST_CMD : `RST_REC;
            presc[0] <= `RST_PRESC;
            presc[1] <= `RST_PRESC;
            ctrl     <= '0;
            pend     <= 1'b0;
            pend_cmd <= '0;
        end else begin
            if (wr_en && dp_tim) timing[dp_off] <= hwdata[7:0];
            if (wr_en && dp_idx == `IDX_CTRL) ctrl <= hwdata[`CTRL_W-1:0];
            if (wr_en && dp_idx == `IDX_PRESC) begin
                presc[0] <= hwdata[7:0];
                presc[1] <= hwdata[`PRESC1_LO+7:`PRESC1_LO];
            end
            if (launch) begin
                pend     <= 1'b1;
                pend_cmd <= cycle_s'(hwdata[`CYC_W-1:0]);
            end else if (start && go_prog) pend <= 1'b0;
        end
    end

    // phase sequencing; the command phase holds at its last count while wait is low
    always_comb begin
        next_state = state;
        next_cnt   = (tick && cnt > 16'h1) ? cnt - 16'h1 : cnt;
        unique case (state)
            S_IDLE: if (start) begin
                next_state = S_SETUP;
                next_cnt   = s_len;
            end
            S_SETUP: if (last) begin
                next_state = S_CMD;
                next_cnt   = lat_c;
            end
            S_CMD: if (last && wait_s) begin
                next_state = waited ? S_TAIL : S_RECOV;
                next_cnt   = waited ? 16'(`WAIT_TAIL) : lat_r;
            end
            S_TAIL: if (last) begin
                next_state = S_RECOV;
                next_cnt   = lat_r;
            end
            S_RECOV: if (last) next_state = S_IDLE;
        endcase
    end

    // state, lengths and per-cycle flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state  <= S_IDLE;
            cnt    <= 16'h0;
            lat_s  <= 16'h0;
            lat_c  <= 16'h0;
            lat_r  <= 16'h0;
            cur    <= '0;
            waited <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            if (start) begin
                lat_s <= s_len;
                lat_c <= c_len;
                lat_r <= r_len;
                cur   <= start_cmd;
            end
            waited <= start ? 1'b0 : waited || (state == S_CMD && !wait_s);
        end
    end

    // iois16 is honoured only inside the window after the cycle begins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win     <= 2'h0;
            io16    <= 1'b0;
            tc_seen <= 1'b0;
        end else if (start) begin
            win     <= 2'h0;
            io16    <= 1'b0;
            tc_seen <= tc_s;                                       // set wins over the clear
        end else if (state != S_IDLE) begin
            if (tick && win != WIN) win <= win + 2'h1;
            if (win != WIN && !iois_s) io16 <= 1'b1;
            if (tc_s) tc_seen <= 1'b1;
        end
    end

    // next socket levels, registered so every pin comes from a flop
    cycle_s nc;
    assign nc = start ? start_cmd : cur;
    wire on_strobe = next_state == S_CMD || next_state == S_TAIL;
    wire card_tc   = on_strobe && (tc_seen || tc_s);
    wire narrow    = !start && win == WIN && !io16;
    wire io_odd    = (nc.kind == K_IO_RD || nc.kind == K_IO_WR) && nc.odd;
    // ce_n[1] is CE2: odd byte on the high lane until the card proves narrow
    wire [1:0] next_ce_n = !ctrl[`CTRL_HOST16] ? 2'b10 :
                           io_odd ? (narrow ? 2'b10 : 2'b01) : 2'b00;
    sock_s next_sock;
    always_comb begin
        next_sock = SOCK_IDLE;
        if (next_state != S_IDLE) begin
            next_sock.ce_n  = next_ce_n;
            next_sock.reg_n = !nc.attr;
            unique case (nc.kind)
                K_MEM_RD: next_sock.oe_n   = !on_strobe;
                K_MEM_WR: next_sock.we_n   = !on_strobe;
                K_IO_RD:  next_sock.iord_n = !on_strobe;
                K_IO_WR:  next_sock.iowr_n = !on_strobe;
                K_DMA_RD: begin
                    next_sock.iowr_n = !on_strobe;
                    next_sock.we_n   = !card_tc;
                end
                K_DMA_WR: begin
                    next_sock.iord_n = !on_strobe;
                    next_sock.oe_n   = !card_tc;
                end
                default: next_sock = SOCK_IDLE;
            endcase
        end
    end

    // output flops; read data is taken as the strobe ends
    wire strobe_end = (state == S_CMD || state == S_TAIL) && next_state == S_RECOV;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sock      <= SOCK_IDLE;
            card_addr <= 26'h0;
            card_dout <= '0;
            card_doe  <= 1'b0;
            dma_req   <= 1'b0;
            rd_latch  <= '0;
        end else begin
            sock      <= next_sock;
            card_doe  <= next_state != S_IDLE && drives_data(nc.kind);
            if (start) card_addr <= start_cmd.addr;
            if (start) card_dout <= go_prog ? f_out_data : dma_wdata;
            dma_req   <= ctrl[`CTRL_DMA_EN] && f_empty && !pend;
            if (strobe_end && !drives_data(cur.kind)) rd_latch <= din_s;
        end
    end
    assign dma_rdata = rd_latch;

    // cycles spent in the current phase, for the checks below
    logic [19:0] stay;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) stay <= 20'h0;
        else stay <= (next_state != state) ? 20'h0 : stay + 20'h1;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_setup_len: assert property (
        state == S_SETUP && next_state != S_SETUP |-> stay + 20'h1 == 20'(lat_s) * 20'(TCPC))
        else $error("setup phase length wrong");
    a_cmd_len: assert property (
        state == S_CMD && next_state != S_CMD && !waited |-> stay + 20'h1 == 20'(lat_c) * 20'(TCPC))
        else $error("command phase length wrong");
    a_recov_len: assert property (
        state == S_RECOV && next_state == S_IDLE |-> stay + 20'h1 == 20'(lat_r) * 20'(TCPC))
        else $error("recovery phase length wrong");
    a_addr_hold: assert property (
        state == S_RECOV |=> $stable(card_addr) && sock.oe_n && sock.we_n && sock.iord_n && sock.iowr_n)
        else $error("address or strobe moved in recovery");
    a_tick_rate: assert property (
        tick |=> !tick [*4] ##1 tick)
        else $error("internal period is not five clocks");
    a_dmard_tc: assert property (
        !sock.we_n && cur.kind == K_DMA_RD |-> !sock.iowr_n)
        else $error("dma read terminal count outside strobe");
    a_dmawr_tc: assert property (
        !sock.oe_n && cur.kind == K_DMA_WR |-> !sock.iord_n)
        else $error("dma write terminal count outside strobe");
    a_wait_tail: assert property (
        state == S_CMD && next_state == S_TAIL |=> !(sock.iord_n && sock.iowr_n && sock.oe_n
            && sock.we_n) [*8] ##1 state == S_TAIL ##1 state == S_TAIL ##1 state == S_RECOV)
        else $error("strobe released too soon after wait");
    a_req_drained: assert property (
        $rose(dma_req) |-> $past(f_empty) && !$past(pend))
        else $error("dma request with write data pending");
    a_narrow_ce: assert property (
        state != S_IDLE && next_state != S_IDLE && !start && io_odd && narrow
            && ctrl[`CTRL_HOST16] |=> sock.ce_n == 2'b10)
        else $error("narrow io access kept CE2");

    c_wait_stretch: cover property (state == S_TAIL);
    c_dma_tc: cover property (!sock.we_n && cur.kind == K_DMA_RD);
    c_fifo_stall: cover property (!hreadyout [*2]);
    c_narrow: cover property (sock.ce_n == 2'b01 ##1 sock.ce_n == 2'b10);

endmodule : pc_card_cycle_timing_dma

/* File: sim/card_model.sv */
// Purpose: card in the socket, answers the device's strobes
// Assumes: no pull-ups on the data lines
// Notes: a stretch holds wait low for the first 40 clocks of a strobe
`timescale 1ns/10ps
module card_model
    import pcc_timing_pkg::*;
(
    input  wire logic        clk,      // bus clock
    input  wire sock_s       sock,     // socket strobes
    input  wire logic [25:0] addr,     // socket address
    input  wire logic        stretch,  // stretch each strobe
    input  wire logic        io16,     // claim 16-bit io
    output logic      [15:0] din,      // data to device
    output logic             wait_n,   // wait, low
    output logic             iois16_n  // 16-bit io, low
);
    logic [5:0] n = 6'h00;
    wire rd_on  = !(sock.oe_n && sock.iord_n);
    wire any_on = rd_on || !(sock.we_n && sock.iowr_n);
    // released data toggles every cycle so a stale word never matches
    always @(posedge clk) begin
        n <= !any_on ? 6'h00 : n + 6'(n != 6'h28);
        din <= rd_on ? addr[15:0] ^ 16'hA5A5 : ~din;
    end
    // wait goes low at strobe start, well before the count runs out
    assign wait_n   = !(stretch && any_on && n < 6'h28);
    assign iois16_n = !(io16 && sock.ce_n != 2'b11);
endmodule : card_model

/* File: sim/pc_card_cycle_timing_dma_tb.sv */
// Purpose: self-checking bench for the socket cycle sequencer
// Assumes: 125 MHz hclk, one internal period per five clocks
// Notes: durations are counted in hclk edges at the socket pins
`timescale 1ns/10ps
`include "pcc_timing_regs.svh"
module pc_card_cycle_timing_dma_tb
    import pcc_timing_pkg::*;
();
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp, card_doe, dma_req, wait_n, iois16_n, e_seen;
    logic        dma_ack = 1'b0, dma_tc = 1'b0, stretch = 1'b0, io16 = 1'b0;
    logic [15:0] card_dout, card_din, dma_rdata, d_seen;
    logic [25:0] card_addr, a_seen;
    sock_s       sock, st;
    int          err_total = 0, compares = 0, cyc = 0, s, c, r;
    wire         off = &{sock.oe_n, sock.we_n, sock.iord_n, sock.iowr_n};
    pc_card_cycle_timing_dma uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sock(sock),
        .card_addr(card_addr), .card_dout(card_dout), .card_doe(card_doe),
        .card_din(card_din), .wait_n(wait_n), .iois16_n(iois16_n), .dma_req(dma_req),
        .dma_ack(dma_ack), .dma_tc(dma_tc), .dma_wdata(16'h5A5A), .dma_rdata(dma_rdata));
    card_model u_card (.clk(hclk), .sock(sock), .addr(card_addr), .stretch(stretch),
        .io16(io16), .din(card_din), .wait_n(wait_n), .iois16_n(iois16_n));
    initial forever #4 hclk = ~hclk;
    // a hang is cut short well after the last cycle should be done
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    // one socket cycle: setup, strobe and recovery lengths, sampled mid-strobe
    task automatic meas();
        s = 0;
        c = 0;
        r = 0;
        while (sock.ce_n === 2'b11) @(posedge hclk);
        while (off === 1'b1) begin @(posedge hclk); s++; end
        dma_ack <= 1'b0;
        while (off === 1'b0) begin
            @(posedge hclk);
            c++;
            if (c == 10) begin
                st = sock; a_seen = card_addr; d_seen = card_dout; e_seen = card_doe;
            end
        end
        while (sock.ce_n !== 2'b11) begin @(posedge hclk); r++; end
    endtask : meas
    task automatic t_regs();
        logic [7:0] v [6] = '{8'h01, 8'h06, 8'h03, 8'h01, 8'h06, 8'h03};
        for (int i = 0; i < 6; i++) begin
            ahb(1'b0, 8'(`IDX_SETUP0 + i), 32'h0);
            check("timing reg", rd, v[i]);
        end
        ahb(1'b0, 8'h50, 32'h0);
        check("unmapped", rd, 32'h0);
        check("hresp", hresp, 1'b0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_time();
        ahb(1'b1, `IDX_CYCLE, 32'h0000_0123);
        meas();
        check("setup", s, `TCP_CYC * 2);
        check("command", c, `TCP_CYC * 7);
        check("recovery", r, `TCP_CYC * 4);
        check("addr held", a_seen, 26'h123);
        check("read data", dma_rdata, 16'h0123 ^ 16'hA5A5);
        // set 1 with prescaler 2 and setup value 2
        ahb(1'b1, `IDX_PRESC, 32'h0201);
        ahb(1'b1, `IDX_SETUP1, 32'h02);
        ahb(1'b1, `IDX_CTRL, 32'h1);
        ahb(1'b1, `IDX_CYCLE, 32'h0000_0045);
        meas();
        check("set1 setup", s, `TCP_CYC * 5);
        check("set1 command", c, `TCP_CYC * 13);
        check("set1 recovery", r, `TCP_CYC * 7);
        ahb(1'b1, `IDX_CTRL, 32'h0);
        $display("t_time done");
    endtask : t_time
    task automatic t_dma();
        stretch <= 1'b1;
        for (int d = 0; d < 2; d++) begin
            ahb(1'b1, `IDX_CTRL, 32'h2 | (d << 2));
            repeat (3) @(posedge hclk);
            check("dma_req", dma_req, 1'b1);
            dma_ack <= 1'b1;
            dma_tc <= 1'b1;
            meas();
            dma_tc <= 1'b0;
            check("strobe held", c >= 50, 1'b1);
            check("iowr", st.iowr_n, d);
            check("iord", st.iord_n, !d);
            check("tc on we", st.we_n, d);
            check("tc on oe", st.oe_n, !d);
            check("dma data", d_seen, 16'h5A5A);
            check("data drive", e_seen, !d);
        end
        stretch <= 1'b0;
        $display("t_dma done");
    endtask : t_dma
    task automatic t_fifo();
        ahb(1'b1, `IDX_CTRL, 32'h2);
        for (int i = 0; i < 4; i++) ahb(1'b1, `IDX_WDATA, 32'h1100 + i);
        ahb(1'b0, `IDX_STATUS, 32'h0);
        check("fifo full", rd[3:1], 3'b010);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, `IDX_CYCLE, 32'h1000_0200 + i);
            meas();
            check("fifo order", d_seen, 16'h1100 + i);
        end
        repeat (3) @(posedge hclk);
        check("dma_req drained", dma_req, 1'b1);
        ahb(1'b1, `IDX_CTRL, 32'h0);
        $display("t_fifo done");
    endtask : t_fifo
    task automatic t_odd();
        ahb(1'b1, `IDX_CTRL, 32'h8);
        // second pass: the card claims 16-bit io, so CE2 must stay on
        for (int w = 0; w < 2; w++) begin
            io16 <= w[0];
            ahb(1'b1, `IDX_CYCLE, 32'h2800_0101);
            while (sock.ce_n === 2'b11) @(posedge hclk);
            check("odd ce start", sock.ce_n, 2'b01);
            repeat (`TCP_CYC * `IOIS_WIN + 5) @(posedge hclk);
            check("odd ce byte", sock.ce_n, w ? 2'b01 : 2'b10);
            while (sock.ce_n !== 2'b11) @(posedge hclk);
        end
        $display("t_odd done");
    endtask : t_odd
    task automatic test_done();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_time();
        t_dma();
        t_fifo();
        t_odd();
        test_done();
    end
endmodule : pc_card_cycle_timing_dma_tb
